// File: hw/spf_framer.sv
// Serial packet framer: frame parser, acknowledger and reply framer
//
// Behaviour
// R1: Frame is start 0x5A, type, length, checksum, then payload from byte six.
// R2: Length is 16 bits and counts payload bytes only.
// R3: Checksum covers start, type, length, payload; skips checksum bytes.
// R4: Checksum starts at zero, byte into top, eight shifts with 0x1021.
// R5: Sync frame is only start byte and a 0xAn type byte.
// R6: Type 0xA1 says previous packet arrived intact.
// R7: Type 0xA2 says previous packet corrupted; sender resends it.
// R8: Type 0xA3 says data phase is aborted.
// R9: Type 0xA4 carries a command payload, 0xA5 a data payload.
// R10: Type 0xA6 is a liveness probe from the peer.
// R11: Device answers a probe with 0xA7 plus version and option bytes.
// R12: Command packet is at most 32 bytes: header plus seven words.
// R13: Header holds tag, flags, reserved zero byte, parameter count.
// R14: Exactly parameter-count words follow the header.
// R15: Device replies using the same command packet layout.
// R16: Command and data packets always travel inside a frame.
// R17: Device recognises only the listed command tags.
// R18: General reply uses 0xA0; property reply only for property queries.
// R19: Flag bit 0 set means data packets follow the command.
// R20: Data phase size comes from a parameter word, not the flags.
// R21: Multi-byte fields travel least significant byte first.
// R22: Host probes and gets the reply before any other packet.
// R23: Property query reply carries tag 0xA7 in header byte 0.
// R24: Receiver skips bytes until start; bad checksum answered with resend.
// R25: Length above 32 bytes is treated as corrupt and answered with resend.
`timescale 1ns/100ps
module spf_framer #(
	parameter logic [23:0] VER_INIT = spf_pkg::VER_RST,
	parameter logic [15:0] OPT_INIT = spf_pkg::OPT_RST
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  spf_pkg::spf_bus_type      reg_req,
	output logic [31:0]               reg_rdata,
	input  spf_pkg::spf_byte_type     rx_in,
	output logic                      tx_valid,
	output logic [7:0]                tx_data,
	input  wire logic                 tx_ready
);

	typedef struct packed {
		spf_pkg::spf_rx_type rx_st;
		logic [7:0]          rx_type;
		logic [15:0]         rx_len;
		logic [15:0]         rx_crc;
		logic [15:0]         rx_calc;
		logic [15:0]         rx_cnt;
		logic [31:0][7:0]    rx_pl;
		logic [31:0][7:0]    cmd;
		logic                linked;
		logic                cmd_new;
		logic                bad_tag;
		logic                abort_seen;
		logic                wait_ack;
		logic                flag_data;
		logic [15:0]         nak_cnt;
		logic [15:0]         data_cnt;
		logic                ack_req;
		logic                nak_req;
		logic                ping_req;
		logic                reply_req;
		spf_pkg::spf_tx_type tx_st;
		logic [39:0][7:0]    tx_buf;
		logic [5:0]          tx_len;
		logic [5:0]          tx_idx;
		logic [5:0]          tx_crcpos;
		logic [15:0]         tx_crc;
		logic                ctl_prop;
		logic [2:0]          ctl_cnt;
		logic [23:0]         ver;
		logic [15:0]         opt;
		logic [6:0][31:0]    tparam;
		logic [31:0]         rdata;
	} spf_state_type;

	spf_state_type q, n;
	logic       fin;
	logic       bad;
	logic       go_s;
	logic       go_p;
	logic       go_r;
	logic [7:0] pcnt;
	logic [7:0] rtag;
	logic [5:0] rlen;

	always_comb begin
		n    = q;
		fin  = 1'b0;
		bad  = 1'b0;
		go_s = 1'b0;
		go_p = 1'b0;
		go_r = 1'b0;
		pcnt = 8'h00;
		// Property reply tag is only allowed after a property query
		rtag = (q.ctl_prop && q.cmd[0] == spf_pkg::PROPERTY_QUERY) ?
			spf_pkg::PROPERTY_REPLY : spf_pkg::GENERAL_REPLY; // R18 R23
		rlen = {1'b0, q.ctl_cnt, 2'b00} + 6'd4; // R12 R2

		// Transmit side runs first so that later sets win over its clears
		unique case (q.tx_st)
			spf_pkg::TX_IDLE: begin
				n.tx_idx = 6'd0;
				n.tx_crc = 16'h0000; // R4
				if (q.nak_req || q.ack_req) begin
					go_s = 1'b1;
					n.tx_buf = '0;
					n.tx_buf[0] = spf_pkg::START_CODE; // R5
					n.tx_buf[1] = q.nak_req ? spf_pkg::FRAME_RESEND_CODE :
						spf_pkg::FRAME_OK_CODE; // R6 R7
					if (q.nak_req)
						n.nak_req = 1'b0;
					else
						n.ack_req = 1'b0;
					n.tx_len = 6'd2;
					n.tx_crcpos = 6'd62;
					n.tx_st = spf_pkg::TX_SEND;
				end else if (q.ping_req) begin
					go_p = 1'b1;
					n.tx_buf = '0;
					n.tx_buf[0] = spf_pkg::START_CODE;
					n.tx_buf[1] = spf_pkg::PROBE_REPLY_CODE; // R11
					n.tx_buf[4:2] = {q.ver[23:16], q.ver[15:8], q.ver[7:0]};
					n.tx_buf[5] = spf_pkg::PROTO_NAME;
					n.tx_buf[7:6] = {q.opt[15:8], q.opt[7:0]}; // R21
					n.ping_req = 1'b0;
					n.tx_len = 6'd10;
					n.tx_crcpos = 6'd8;
					n.tx_st = spf_pkg::TX_CALC;
				end else if (q.reply_req) begin
					go_r = 1'b1;
					n.tx_buf = '0;
					n.tx_buf[0] = spf_pkg::START_CODE; // R1 R16
					n.tx_buf[1] = spf_pkg::FRAME_CMD_CODE; // R9
					n.tx_buf[2] = {2'b00, rlen}; // R2 R21
					n.tx_buf[9:6] = {5'h00, q.ctl_cnt, 16'h0000, rtag}; // R13 R15
					for (int k = 0; k < 7; k++) begin
						n.tx_buf[10 + 4 * k +: 4] = q.tparam[k]; // R14 R21
					end
					n.reply_req = 1'b0;
					n.wait_ack = 1'b1;
					n.tx_len = rlen + 6'd6;
					n.tx_crcpos = 6'd4;
					n.tx_st = spf_pkg::TX_CALC;
				end
			end
			spf_pkg::TX_CALC: begin
				if (q.tx_idx != q.tx_crcpos && q.tx_idx != q.tx_crcpos + 6'd1)
					n.tx_crc = spf_pkg::spf_crc_step(q.tx_crc,
						q.tx_buf[q.tx_idx]); // R3 R4
				n.tx_idx = q.tx_idx + 6'd1;
				if (q.tx_idx == q.tx_len - 6'd1) begin
					n.tx_buf[q.tx_crcpos] = n.tx_crc[7:0]; // R21
					n.tx_buf[q.tx_crcpos + 6'd1] = n.tx_crc[15:8];
					n.tx_idx = 6'd0;
					n.tx_st = spf_pkg::TX_SEND;
				end
			end
			spf_pkg::TX_SEND: begin
				if (tx_ready) begin
					// Shifting keeps the outgoing byte in a flip-flop
					n.tx_buf = {8'h00, q.tx_buf[39:1]};
					n.tx_idx = q.tx_idx + 6'd1;
					if (q.tx_idx == q.tx_len - 6'd1)
						n.tx_st = spf_pkg::TX_IDLE;
				end
			end
			default: n.tx_st = spf_pkg::TX_IDLE;
		endcase

		// Register bus
		n.rdata = 32'h0000_0000;
		if (reg_req.rd) begin
			if (reg_req.addr[6])
				n.rdata = (reg_req.addr[4:2] == 3'h7) ? 32'h0 :
					q.tparam[reg_req.addr[4:2]];
			else if (reg_req.addr[6:5] == spf_pkg::RXPAR_SEL)
				n.rdata = (reg_req.addr[4:2] == 3'h7) ? 32'h0 :
					q.cmd[4 + 4 * reg_req.addr[4:2] +: 4]; // R21
			else begin
				case (reg_req.addr)
					spf_pkg::CTRL_OFS: begin
						n.rdata[spf_pkg::CTL_PROP] = q.ctl_prop;
						n.rdata[spf_pkg::CTL_CNT +: 3] = q.ctl_cnt;
					end
					spf_pkg::STATUS_OFS: begin
						n.rdata[spf_pkg::ST_LINK] = q.linked;
						n.rdata[spf_pkg::ST_CMD] = q.cmd_new;
						n.rdata[spf_pkg::ST_BADTAG] = q.bad_tag;
						n.rdata[spf_pkg::ST_ABORT] = q.abort_seen;
						n.rdata[spf_pkg::ST_BUSY] =
							q.tx_st != spf_pkg::TX_IDLE;
						n.rdata[spf_pkg::ST_WAIT] = q.wait_ack;
						n.rdata[spf_pkg::ST_DFLAG] = q.flag_data; // R19
					end
					spf_pkg::RXHDR_OFS:   n.rdata = q.cmd[3:0];
					spf_pkg::VERSION_OFS: n.rdata = {8'h00, q.ver};
					spf_pkg::OPTION_OFS:  n.rdata = {16'h0000, q.opt};
					spf_pkg::COUNT_OFS:   n.rdata = {q.data_cnt, q.nak_cnt};
					default:              n.rdata = 32'h0000_0000;
				endcase
			end
		end
		if (reg_req.wr) begin
			if (reg_req.addr[6] && reg_req.addr[4:2] != 3'h7)
				n.tparam[reg_req.addr[4:2]] = reg_req.wdata;
			case (reg_req.addr)
				spf_pkg::CTRL_OFS: begin
					n.ctl_prop = reg_req.wdata[spf_pkg::CTL_PROP];
					// Counts above seven would overrun a 32-byte packet
					n.ctl_cnt = reg_req.wdata[spf_pkg::CTL_CNT +: 3]; // R12
					if (reg_req.wdata[spf_pkg::CTL_SEND])
						n.reply_req = 1'b1;
				end
				spf_pkg::STATUS_OFS: begin
					if (reg_req.wdata[spf_pkg::ST_CMD])
						n.cmd_new = 1'b0;
					if (reg_req.wdata[spf_pkg::ST_BADTAG])
						n.bad_tag = 1'b0;
					if (reg_req.wdata[spf_pkg::ST_ABORT])
						n.abort_seen = 1'b0;
				end
				spf_pkg::VERSION_OFS: n.ver = reg_req.wdata[23:0];
				spf_pkg::OPTION_OFS:  n.opt = reg_req.wdata[15:0];
				default: ;
			endcase
		end

		// Receive side
		if (rx_in.valid) begin
			n.rx_calc = spf_pkg::spf_crc_step(q.rx_calc, rx_in.data); // R3
			unique case (q.rx_st)
				spf_pkg::RX_IDLE: begin
					n.rx_calc = spf_pkg::spf_crc_step(16'h0000,
						rx_in.data); // R4
					if (rx_in.data == spf_pkg::START_CODE)
						n.rx_st = spf_pkg::RX_TYPE; // R24
				end
				spf_pkg::RX_TYPE: begin
					n.rx_type = rx_in.data;
					n.rx_st = spf_pkg::RX_IDLE; // R5
					case (rx_in.data)
						// A reply loaded in this same cycle keeps waiting
						spf_pkg::FRAME_OK_CODE: n.wait_ack = go_r; // R6
						spf_pkg::FRAME_RESEND_CODE:
							if (q.wait_ack)
								n.reply_req = 1'b1; // R7
						spf_pkg::PHASE_ABORT_CODE: n.abort_seen = 1'b1; // R8
						spf_pkg::PROBE_CODE: begin
							n.ping_req = 1'b1; // R10
							n.linked = 1'b1; // R22
						end
						spf_pkg::FRAME_CMD_CODE, spf_pkg::FRAME_BULK_CODE:
							n.rx_st = spf_pkg::RX_LEN0; // R9
						default: ;
					endcase
				end
				spf_pkg::RX_LEN0: begin
					n.rx_len[7:0] = rx_in.data; // R21
					n.rx_st = spf_pkg::RX_LEN1;
				end
				spf_pkg::RX_LEN1: begin
					n.rx_len[15:8] = rx_in.data;
					n.rx_st = spf_pkg::RX_CRC0;
				end
				spf_pkg::RX_CRC0: begin
					n.rx_calc = q.rx_calc; // R3
					n.rx_crc[7:0] = rx_in.data;
					n.rx_st = spf_pkg::RX_CRC1;
				end
				spf_pkg::RX_CRC1: begin
					n.rx_calc = q.rx_calc;
					n.rx_crc[15:8] = rx_in.data;
					n.rx_cnt = 16'h0000;
					if (q.rx_len == 16'h0000)
						fin = 1'b1;
					else
						n.rx_st = spf_pkg::RX_PAY; // R1
				end
				spf_pkg::RX_PAY: begin
					// Oversized payload is drained to stay in step
					if (q.rx_cnt < spf_pkg::MAX_PAYLOAD)
						n.rx_pl[q.rx_cnt[4:0]] = rx_in.data;
					n.rx_cnt = q.rx_cnt + 16'h0001;
					if (n.rx_cnt == q.rx_len)
						fin = 1'b1;
				end
				default: n.rx_st = spf_pkg::RX_IDLE;
			endcase
		end
		if (fin) begin
			n.rx_st = spf_pkg::RX_IDLE;
			pcnt = n.rx_pl[3];
			bad = n.rx_calc != n.rx_crc; // R24
			if (n.rx_len > spf_pkg::MAX_PAYLOAD)
				bad = 1'b1; // R25
			if (n.rx_type == spf_pkg::FRAME_CMD_CODE &&
				(pcnt > spf_pkg::MAX_PARAMS ||
				n.rx_len != {6'h00, pcnt, 2'b00} + 16'h0004))
				bad = 1'b1; // R12 R14
			if (bad) begin
				n.nak_req = 1'b1; // R24 R25
				n.nak_cnt = q.nak_cnt + 16'h0001;
			end else begin
				n.ack_req = 1'b1; // R6
				if (n.rx_type == spf_pkg::FRAME_CMD_CODE) begin
					n.cmd = n.rx_pl; // R13
					n.cmd_new = 1'b1;
					n.bad_tag = !spf_pkg::spf_tag_ok(n.rx_pl[0]); // R17
					// Transfer size is left to software via the params
					n.flag_data = n.rx_pl[1][0]; // R19 R20
				end else begin
					n.data_cnt = q.data_cnt + 16'h0001;
					if (n.rx_len == 16'h0000)
						n.abort_seen = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.ver <= VER_INIT;
			q.opt <= OPT_INIT;
			q.ctl_cnt <= spf_pkg::CNT_RST;
		end else begin
			q <= n;
		end
	end

	assign reg_rdata = q.rdata;
	assign tx_valid  = q.tx_st == spf_pkg::TX_SEND;
	assign tx_data   = q.tx_buf[0];

	property p_start;
		@(posedge sys_clk) disable iff (rst)
		$rose(tx_valid) |-> tx_data == spf_pkg::START_CODE;
	endproperty
	a_start: assert property (p_start) else $error("frame start wrong"); // R1

	property p_hunt;
		@(posedge sys_clk) disable iff (rst)
		rx_in.valid && q.rx_st == spf_pkg::RX_IDLE &&
		rx_in.data != spf_pkg::START_CODE |=> q.rx_st == spf_pkg::RX_IDLE;
	endproperty
	a_hunt: assert property (p_hunt) else $error("left hunt early"); // R24

	property p_bad;
		@(posedge sys_clk) disable iff (rst)
		fin && (n.rx_calc != n.rx_crc || n.rx_len > spf_pkg::MAX_PAYLOAD)
		|=> q.nak_req && $stable(q.cmd) && q.rx_st == spf_pkg::RX_IDLE &&
		q.nak_cnt == $past(q.nak_cnt) + 16'h0001;
	endproperty
	a_bad: assert property (p_bad) else $error("bad frame not refused"); // R25

	property p_probe;
		@(posedge sys_clk) disable iff (rst)
		go_p |=> q.tx_buf[1] == spf_pkg::PROBE_REPLY_CODE && q.tx_len == 6'd10
		##[1:12] tx_valid;
	endproperty
	a_probe: assert property (p_probe) else $error("probe reply wrong"); // R11

	property p_resend;
		@(posedge sys_clk) disable iff (rst)
		rx_in.valid && q.rx_st == spf_pkg::RX_TYPE && q.wait_ack &&
		rx_in.data == spf_pkg::FRAME_RESEND_CODE |=> q.reply_req;
	endproperty
	a_resend: assert property (p_resend) else $error("no resend"); // R7

	property p_tag;
		@(posedge sys_clk) disable iff (rst)
		go_r |=> q.tx_buf[6] == ($past(q.ctl_prop) &&
		$past(q.cmd[0]) == spf_pkg::PROPERTY_QUERY ? 8'hA7 : 8'hA0);
	endproperty
	a_tag: assert property (p_tag) else $error("reply tag wrong"); // R18

	property p_len;
		@(posedge sys_clk) disable iff (rst)
		go_r |=> q.tx_buf[2] == {3'h0, $past(q.ctl_cnt), 2'b00} + 8'h04 &&
		q.tx_buf[3] == 8'h00 && q.tx_len == q.tx_buf[2][5:0] + 6'd6;
	endproperty
	a_len: assert property (p_len) else $error("reply length wrong"); // R2

	property p_short;
		@(posedge sys_clk) disable iff (rst)
		go_s |=> q.tx_len == 6'd2 && tx_valid &&
		tx_data == spf_pkg::START_CODE ##1 tx_valid;
	endproperty
	a_short: assert property (p_short) else $error("sync frame wrong"); // R5

	property p_cmd;
		@(posedge sys_clk) disable iff (rst)
		fin && !bad && n.rx_type == spf_pkg::FRAME_CMD_CODE |=>
		q.cmd_new && q.ack_req && q.cmd[3] <= spf_pkg::MAX_PARAMS;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command not taken"); // R14
endmodule

// File: hw/spf_pkg.sv
// Constants, types and checksum helper for the serial packet framer
package spf_pkg;
	localparam logic [7:0]  START_CODE       = 8'h5A;
	localparam logic [7:0]  FRAME_OK_CODE    = 8'hA1;
	localparam logic [7:0]  FRAME_RESEND_CODE = 8'hA2;
	localparam logic [7:0]  PHASE_ABORT_CODE = 8'hA3;
	localparam logic [7:0]  FRAME_CMD_CODE   = 8'hA4;
	localparam logic [7:0]  FRAME_BULK_CODE  = 8'hA5;
	localparam logic [7:0]  PROBE_CODE       = 8'hA6;
	localparam logic [7:0]  PROBE_REPLY_CODE = 8'hA7;
	localparam logic [7:0]  GENERAL_REPLY    = 8'hA0;
	localparam logic [7:0]  PROPERTY_REPLY   = 8'hA7;
	localparam logic [7:0]  PROPERTY_QUERY   = 8'h07;
	localparam logic [7:0]  PROTO_NAME       = 8'h50;
	localparam logic [15:0] CRC_POLY         = 16'h1021;
	localparam logic [15:0] MAX_PAYLOAD      = 16'h0020;
	localparam logic [7:0]  MAX_PARAMS       = 8'h07;
	// Register offsets
	localparam logic [6:0]  CTRL_OFS    = 7'h00;
	localparam logic [6:0]  STATUS_OFS  = 7'h04;
	localparam logic [6:0]  RXHDR_OFS   = 7'h08;
	localparam logic [6:0]  VERSION_OFS = 7'h0C;
	localparam logic [6:0]  OPTION_OFS  = 7'h10;
	localparam logic [6:0]  COUNT_OFS   = 7'h14;
	localparam logic [1:0]  RXPAR_SEL   = 2'h1;
	// Field positions
	localparam int CTL_SEND  = 0;
	localparam int CTL_PROP  = 1;
	localparam int CTL_CNT   = 8;
	localparam int ST_LINK   = 0;
	localparam int ST_CMD    = 1;
	localparam int ST_BADTAG = 2;
	localparam int ST_ABORT  = 3;
	localparam int ST_BUSY   = 4;
	localparam int ST_WAIT   = 5;
	localparam int ST_DFLAG  = 6;
	// Reset values
	localparam logic [23:0] VER_RST = 24'h01_01_00;
	localparam logic [15:0] OPT_RST = 16'h0000;
	localparam logic [2:0]  CNT_RST = 3'h2;

	typedef struct packed {
		logic [6:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} spf_bus_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} spf_byte_type;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_TYPE = 3'b001,
		RX_LEN0 = 3'b010,
		RX_LEN1 = 3'b011,
		RX_CRC0 = 3'b100,
		RX_CRC1 = 3'b101,
		RX_PAY  = 3'b110
	} spf_rx_type;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_CALC = 2'b01,
		TX_SEND = 2'b10
	} spf_tx_type;

	function automatic logic [15:0] spf_crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction

	function automatic logic spf_tag_ok(input logic [7:0] t);
		case (t)
			8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09,
			8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage

// File: tb/spf_host_model.sv
// Behavioural host that feeds framed bytes in and sinks outgoing bytes
`timescale 1ns/100ps
module spf_host_model (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             slow,
	input  wire logic             tx_valid,
	input  wire logic [7:0]       tx_data,
	output spf_pkg::spf_byte_type rx_in,
	output logic                  tx_ready
);
	logic [7:0] got[$];
	logic       tick_q;

	initial begin
		rx_in = '0;
		tx_ready = 1'b0;
		tick_q = 1'b0;
	end

	// Slow mode drops ready on alternate cycles so the sender must hold
	always @(posedge sys_clk) begin
		tick_q <= ~tick_q;
		tx_ready <= !rst && (!slow || tick_q);
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
		end
	end

	// Idle data shows the inverse of the last byte, never a stale copy
	task automatic send_bytes(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge sys_clk);
			rx_in <= '{valid: 1'b1, data: q[i]};
		end
		@(posedge sys_clk);
		rx_in <= '{valid: 1'b0, data: ~rx_in.data};
	endtask
endmodule

// File: tb/spf_framer_tb_top.sv
// Self-checking bench for the serial packet framer
`timescale 1ns/100ps
module spf_framer_tb_top;
	logic                  sys_clk;
	logic                  rst;
	logic                  slow;
	spf_pkg::spf_bus_type  reg_req;
	logic [31:0]           reg_rdata;
	spf_pkg::spf_byte_type rx_in;
	logic                  tx_valid;
	logic [7:0]            tx_data;
	logic                  tx_ready;
	int                    n_mismatch;
	int                    n_compared;
	logic [7:0]            fr[$];
	logic [7:0]            pl[$];
	logic [15:0]           c;

	spf_framer spf_framer_inst (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.reg_req   (reg_req),
		.reg_rdata (reg_rdata),
		.rx_in     (rx_in),
		.tx_valid  (tx_valid),
		.tx_data   (tx_data),
		.tx_ready  (tx_ready)
	);

	spf_host_model spf_host_model_inst (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.slow     (slow),
		.tx_valid (tx_valid),
		.tx_data  (tx_data),
		.rx_in    (rx_in),
		.tx_ready (tx_ready)
	);

	always #2 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus_wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		reg_req <= '0;
	endtask

	// Read data is taken in the one cycle it stands, then must fall to zero
	task automatic rd_chk(input string what, input logic [6:0] a,
		input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] v;
		@(posedge sys_clk);
		reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		reg_req <= '0;
		@(posedge sys_clk);
		v = reg_rdata;
		check(what, v & mask, exp);
		@(posedge sys_clk);
		check("rdata idle", reg_rdata, 32'h0);
	endtask

	function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
		logic [15:0] r;
		r = 16'h0000;
		foreach (q[j]) begin
			r = r ^ {q[j], 8'h00};
			for (int i = 0; i < 8; i++) begin
				r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
			end
		end
		return r;
	endfunction

	task automatic mk_frame(input logic [7:0] typ, input logic [7:0] p[$]);
		logic [7:0] h[$];
		h = {8'h5A, typ, 8'(p.size()), 8'(p.size() >> 8)};
		c = crc_of({h, p});
		fr = {h, c[7:0], c[15:8], p};
	endtask

	task automatic expect_tx(input string what, input logic [7:0] e[$]);
		int k;
		k = 0;
		while (spf_host_model_inst.got.size() < e.size() && k < 600) begin
			@(posedge sys_clk);
			k++;
		end
		check(what, 32'(spf_host_model_inst.got.size()), 32'(e.size()));
		foreach (e[i]) begin
			if (i < spf_host_model_inst.got.size()) begin
				check(what, 32'(spf_host_model_inst.got[i]), 32'(e[i]));
			end
		end
		spf_host_model_inst.got.delete();
	endtask

	task automatic send_cmd(input logic [7:0] tag, input logic [7:0] flg);
		mk_frame(8'hA4, {tag, flg, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00});
		spf_host_model_inst.send_bytes(fr);
	endtask

	task automatic close_out();
		$display("Counts: %0d compared, %0d mismatched", n_compared,
			n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end

	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		slow = 1'b0;
		reg_req = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk("version", 7'h0C, 32'hFFFF_FFFF, 32'h0001_0100);
		rd_chk("ctrl", 7'h00, 32'hFFFF_FFFF, 32'h0000_0200);
		rd_chk("status", 7'h04, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk("unmapped", 7'h7C, 32'hFFFF_FFFF, 32'h0000_0000);
		bus_wr(7'h10, 32'h0000_1234);
		$display("test reset values done");
		// Probe first, behind a junk byte the receiver must skip
		spf_host_model_inst.send_bytes({8'h33, 8'h5A, 8'hA6});
		pl = {8'h5A, 8'hA7, 8'h00, 8'h01, 8'h01, 8'h50, 8'h34, 8'h12};
		c = crc_of(pl);
		expect_tx("probe reply", {pl, c[7:0], c[15:8]});
		rd_chk("linked", 7'h04, 32'h1, 32'h1);
		$display("test probe done");
		send_cmd(8'h07, 8'h01);
		expect_tx("ack", {8'h5A, 8'hA1});
		rd_chk("header", 7'h08, 32'hFFFF_FFFF, 32'h0100_0107);
		rd_chk("param0", 7'h20, 32'hFFFF_FFFF, 32'h0000_0001);
		rd_chk("cmd flags", 7'h04, 32'h46, 32'h42);
		$display("test command done");
		slow <= 1'b1;
		bus_wr(7'h44, 32'hCAFE_0001);
		bus_wr(7'h00, 32'h0000_0203);
		pl = {8'hA7, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h01, 8'h00, 8'hFE, 8'hCA};
		mk_frame(8'hA4, pl);
		expect_tx("prop reply", fr);
		rd_chk("waiting", 7'h04, 32'h20, 32'h20);
		spf_host_model_inst.send_bytes({8'h5A, 8'hA2});
		expect_tx("resent reply", fr);
		spf_host_model_inst.send_bytes({8'h5A, 8'hA1});
		rd_chk("ack clears wait", 7'h04, 32'h20, 32'h00);
		bus_wr(7'h00, 32'h0000_0201);
		pl[0] = 8'hA0;
		mk_frame(8'hA4, pl);
		expect_tx("general reply", fr);
		spf_host_model_inst.send_bytes({8'h5A, 8'hA1});
		slow <= 1'b0;
		$display("test reply done");
		foreach (pl[i]) pl[i] = 8'h00;
		pl = {8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09,
			8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10};
		foreach (pl[i]) begin
			send_cmd(pl[i], 8'h00);
			expect_tx("tag ack", {8'h5A, 8'hA1});
		end
		rd_chk("known tags", 7'h04, 32'h44, 32'h00);
		send_cmd(8'h03, 8'h00);
		expect_tx("unknown tag ack", {8'h5A, 8'hA1});
		rd_chk("unknown tag", 7'h04, 32'h4, 32'h4);
		bus_wr(7'h04, 32'h0000_000E);
		rd_chk("status w1c", 7'h04, 32'h0F, 32'h01);
		$display("test tags done");
		send_cmd(8'h01, 8'h00);
		fr[4] = fr[4] ^ 8'h01;
		expect_tx("stale", {8'h5A, 8'hA1});
		spf_host_model_inst.send_bytes(fr);
		expect_tx("bad crc", {8'h5A, 8'hA2});
		mk_frame(8'hA4, {8'h01, 8'h00, 8'h00, 8'h02,
			8'h00, 8'h00, 8'h00, 8'h00});
		spf_host_model_inst.send_bytes(fr);
		expect_tx("count mismatch", {8'h5A, 8'hA2});
		pl = {8'h01, 8'h00, 8'h00, 8'h08};
		repeat (32) pl.push_back(8'h00);
		mk_frame(8'hA4, pl);
		spf_host_model_inst.send_bytes(fr);
		expect_tx("too long", {8'h5A, 8'hA2});
		mk_frame(8'hA5, {8'h11, 8'h22, 8'h33, 8'h44});
		spf_host_model_inst.send_bytes(fr);
		expect_tx("data ack", {8'h5A, 8'hA1});
		rd_chk("counts", 7'h14, 32'hFFFF_FFFF, 32'h0001_0003);
		spf_host_model_inst.send_bytes({8'h5A, 8'hA3});
		rd_chk("abort", 7'h04, 32'h8, 32'h8);
		bus_wr(7'h04, 32'h0000_0008);
		rd_chk("abort w1c", 7'h04, 32'h8, 32'h0);
		pl.delete();
		mk_frame(8'hA5, pl);
		spf_host_model_inst.send_bytes(fr);
		expect_tx("empty data ack", {8'h5A, 8'hA1});
		rd_chk("empty data abort", 7'h04, 32'h8, 32'h8);
		rd_chk("counts again", 7'h14, 32'hFFFF_FFFF, 32'h0002_0003);
		$display("test refusals done");
		close_out();
	end
endmodule
